// >>> design/rss_countdown.sv
/*
 Countdown timer: busy for exactly len cycles after a start pulse,
 finish marks the last busy cycle. Abort drops it at once.
 Assumes len is at least one and start is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_countdown #(
	parameter int W = `RSS_CNT_W
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic abort,
	input wire logic start,
	input wire logic [W-1:0] len,
	output logic busy,
	output logic finish
);
	import rss_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
	} rss_tmr_t;

	rss_tmr_t q;
	rss_tmr_t d;

	// a start on the last cycle restarts, so a new request is not lost
	always_comb
	begin
		d = q;
		if (abort)
		begin
			d.busy = 1'b0;
			d.cnt = '0;
		end
		else if (start)
		begin
			d.busy = 1'b1;
			d.cnt = len - 1'b1;
		end
		else if (q.busy)
		begin
			if (q.cnt == '0)
				d.busy = 1'b0;
			else
				d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			q <= '0;
		else
			q <= d;
	end

	assign busy = q.busy;
	assign finish = q.busy && (q.cnt == '0);

	start_busy_a: assert property (@(posedge clock) disable iff (!nrst)
		start && !abort |=> busy)
		else $error("timer did not start");
	finish_end_a: assert property (@(posedge clock) disable iff (!nrst)
		finish && !start && !abort |=> !busy)
		else $error("timer ran past its last cycle");

endmodule : rss_countdown

// >>> design/rss_defs.svh
/*
 Constants of the reset source sequencer: clock rate, documented times
 and the cycle counts derived from them, reset values and widths.
 Assumes a single 200 MHz clock; all counts are in cycles of it.
*/
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// clock rate and counter width
`define RSS_CLK_MHZ 200
`define RSS_CNT_W 23

// soft reset self-clears after about 2 us (least time, rounded up)
`define RSS_SOFT_RST_NS 2000
`define RSS_SOFT_RST_CYC ((`RSS_SOFT_RST_NS * `RSS_CLK_MHZ + 999) / 1000)

// phy reset self-clears after about 100 us
`define RSS_PHY_RST_US 100
`define RSS_PHY_RST_CYC (`RSS_PHY_RST_US * `RSS_CLK_MHZ)

// ready set about 22 ms after an internal reset
`define RSS_READY_MS 22
`define RSS_READY_CYC (`RSS_READY_MS * 1000 * `RSS_CLK_MHZ)

// ready set within 2 ms of a wake write (longest time, rounded down)
`define RSS_WAKE_MS 2
`define RSS_WAKE_CYC (`RSS_WAKE_MS * 1000 * `RSS_CLK_MHZ)

// eeprom presence probe, 10 us
`define RSS_EE_PROBE_US 10
`define RSS_EE_PROBE_CYC (`RSS_EE_PROBE_US * `RSS_CLK_MHZ)

// configuration strap width and reset value
`define RSS_STRAP_W 4
`define RSS_STRAP_RST 4'h0

`endif

// >>> design/rss_pkg.sv
/*
 Types of the reset source sequencer: sequencing states, counter type
 and the packed state of the top module.
 Assumes rss_defs.svh is on the include path.
*/
`include "rss_defs.svh"

package rss_pkg;

	typedef logic [`RSS_CNT_W-1:0] rss_count_t;

	// one-hot sequencing states
	typedef enum logic [4:0] {
		RSS_HARD = 5'h01,
		RSS_RDYWAIT = 5'h02,
		RSS_RUN = 5'h04,
		RSS_SLEEP = 5'h08,
		RSS_WAKE = 5'h10
	} rss_state_t;

	typedef struct packed {
		rss_state_t st;
		logic pllRst;
		logic hostBusRst;
		logic keptRegsRst;
		logic miiRst;
		logic macRst;
		logic phyRst;
		logic ready;
		logic eeBusy;
		logic reload;
		logic softBit;
		logic phyPmtBit;
		logic phyBasicBit;
		rss_count_t waitCnt;
		rss_count_t softCnt;
	} rss_main_t;

endpackage : rss_pkg

// >>> design/rss_reset_seq.sv
/*
 Reset source sequencer of a 10/100 ethernet controller: gathers the
 hardware pin, soft reset and two phy reset requests, drives the reset
 of each internal domain, the ready flag, eeprom probe and strap latch.
 Assumes request inputs are one-cycle write pulses, synchronous to clock.
*/
// Behaviour
// R01: only four reset sources are accepted
// R02: hardware pin resets everything, reloads, relatches
// R03: soft reset hits bus, mii, mac, reload
// R04: soft reset leaves preserved registers alone
// R05: pmt bit resets phy, clears after 100us
// R06: basic control bit resets phy, self-clears
// R07: soft bit self-clears after two microseconds
// R08: host holds pin 30ms or soft-resets
// R09: ready reads zero until reset completes
// R10: ready set 22ms after internal reset
// R11: host flags error after 100ms no ready
// R12: host writes control only after ready
// R13: pin may float high; host soft-resets
// R14: ready within 2ms after wake write
// R15: no soft reset before first ready
// R16: probe eeprom after reset; busy flag shown
// R17: host waits for link after phy reset
// R18: host only reads before ready
// R19: request bits read one while reset runs
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_reset_seq #(
	parameter int unsigned PHY_RST_CYC = `RSS_PHY_RST_CYC,
	parameter int unsigned READY_CYC = `RSS_READY_CYC,
	parameter int unsigned WAKE_CYC = `RSS_WAKE_CYC,
	parameter int STRAP_W = `RSS_STRAP_W
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hardResetPinLow,
	input wire logic softResetWrite,
	input wire logic phyRstWrite,
	input wire logic phyBasicRstWrite,
	input wire logic sleepEnter,
	input wire logic wakeWrite,
	input wire logic [STRAP_W-1:0] strapIn,
	output logic pllRst,
	output logic hostBusRst,
	output logic keptRegsRst,
	output logic miiRst,
	output logic macRst,
	output logic phyRst,
	output logic readyBit,
	output logic eepromBusyFlag,
	output logic eepromReload,
	output logic softResetRequest,
	output logic phyPmtResetBit,
	output logic phyBasicResetBit,
	output logic [STRAP_W-1:0] strapLatched
);
	import rss_pkg::*;

	localparam rss_count_t SOFT_LEN = rss_count_t'(`RSS_SOFT_RST_CYC);
	localparam rss_count_t PHY_LEN = rss_count_t'(PHY_RST_CYC);
	localparam rss_count_t READY_LEN = rss_count_t'(READY_CYC);
	localparam rss_count_t WAKE_LEN = rss_count_t'(WAKE_CYC);
	localparam rss_count_t EE_LEN = rss_count_t'(`RSS_EE_PROBE_CYC);

	rss_main_t q;
	rss_main_t d;

	logic hard;
	logic softStart;
	logic softBusy;
	logic softFinish;
	logic phyStart;
	logic phyBusy;
	logic phyFinish;
	logic rdyStart;
	logic rdyBusy;
	logic rdyFinish;
	rss_count_t rdyLen;
	logic eeStart;
	logic eeBusy;
	logic eeFinish;
	logic strapCapture;

	// R13 pin sampled as a plain synchronous level, high means released
	assign hard = !hardResetPinLow;

	// timers: soft reset, phy reset, ready delay, eeprom probe
	rss_countdown #(.W(`RSS_CNT_W)) softTmr (
		.clock(clock),
		.nrst(nrst),
		.abort(hard),
		.start(softStart),
		.len(SOFT_LEN),
		.busy(softBusy),
		.finish(softFinish)
	);

	rss_countdown #(.W(`RSS_CNT_W)) phyTmr (
		.clock(clock),
		.nrst(nrst),
		.abort(hard),
		.start(phyStart),
		.len(PHY_LEN),
		.busy(phyBusy),
		.finish(phyFinish)
	);

	rss_countdown #(.W(`RSS_CNT_W)) rdyTmr (
		.clock(clock),
		.nrst(nrst),
		.abort(hard),
		.start(rdyStart),
		.len(rdyLen),
		.busy(rdyBusy),
		.finish(rdyFinish)
	);

	rss_countdown #(.W(`RSS_CNT_W)) eeTmr (
		.clock(clock),
		.nrst(nrst),
		.abort(hard),
		.start(eeStart),
		.len(EE_LEN),
		.busy(eeBusy),
		.finish(eeFinish)
	);

	// R02 straps relatched only on release of the hardware reset
	rss_strap_latch #(.W(STRAP_W)) straps (
		.clock(clock),
		.nrst(nrst),
		.capture(strapCapture),
		.strapIn(strapIn),
		.strapQ(strapLatched)
	);

	// sequencing, request bits and domain resets in one next-state block
	always_comb
	begin
		d = q;
		d.reload = 1'b0;
		rdyStart = 1'b0;
		rdyLen = READY_LEN;
		strapCapture = 1'b0;
		// R15 soft reset ignored whenever ready is clear, in sleep and wake as well as before first ready
		softStart = softResetWrite && q.ready && !q.softBit && !hard;
		// R01 phy may restart on its last cycle so a write is not lost
		phyStart = (phyRstWrite || phyBasicRstWrite) && (!phyBusy || phyFinish) && !hard;
		// R16 probe after pin release or at the end of a soft reset
		eeStart = 1'b0;

		case (q.st)
			RSS_HARD:
			begin
				if (!hard)
				begin
					// R02 release: reload address and latch straps
					d.st = RSS_RDYWAIT;
					rdyStart = 1'b1;
					rdyLen = READY_LEN;
					eeStart = 1'b1;
					strapCapture = 1'b1;
				end
			end
			RSS_RDYWAIT:
			begin
				// R10 ready after the internal reset delay
				if (rdyFinish)
				begin
					d.st = RSS_RUN;
					d.ready = 1'b1;
				end
			end
			RSS_RUN:
			begin
				if (sleepEnter)
				begin
					d.st = RSS_SLEEP;
					d.ready = 1'b0;
				end
			end
			RSS_SLEEP:
			begin
				if (wakeWrite)
				begin
					// R14 wake write starts the short ready delay
					d.st = RSS_WAKE;
					rdyStart = 1'b1;
					rdyLen = WAKE_LEN;
				end
			end
			RSS_WAKE:
			begin
				if (rdyFinish)
				begin
					d.st = RSS_RUN;
					d.ready = 1'b1;
				end
			end
			default:
			begin
				d.st = RSS_HARD;
				d.ready = 1'b0;
			end
		endcase

		// R07 soft request bit set on write, cleared on last busy cycle
		if (softStart)
			d.softBit = 1'b1;
		else if (softFinish)
			d.softBit = 1'b0;
		// R03 address reload follows the soft reset
		if (softFinish && !hard)
			eeStart = 1'b1;

		// R05 pmt phy bit, set wins over the finishing clear
		if (phyRstWrite && (phyStart || phyBusy))
			d.phyPmtBit = 1'b1;
		else if (phyFinish)
			d.phyPmtBit = 1'b0;
		// R06 basic control phy bit, same scheme
		if (phyBasicRstWrite && (phyStart || phyBusy))
			d.phyBasicBit = 1'b1;
		else if (phyFinish)
			d.phyBasicBit = 1'b0;

		// R16 busy flag while the probe runs, restart keeps it set
		if (eeStart)
			d.eeBusy = 1'b1;
		else if (eeFinish)
			d.eeBusy = 1'b0;
		d.reload = eeStart;

		// R09 pin low overrides everything and holds ready clear
		if (hard)
		begin
			d.st = RSS_HARD;
			d.ready = 1'b0;
			d.softBit = 1'b0;
			d.phyPmtBit = 1'b0;
			d.phyBasicBit = 1'b0;
			d.eeBusy = 1'b0;
			d.reload = 1'b0;
		end

		// R02 pin resets all domains
		d.pllRst = hard;
		// R04 preserved registers follow the pin only
		d.keptRegsRst = hard;
		// R03 soft reset covers bus interface, mii and mac, not phy
		d.hostBusRst = hard || d.softBit;
		d.miiRst = hard || d.softBit;
		d.macRst = hard || d.softBit;
		// R05 phy-only resets reach nothing but the phy
		d.phyRst = hard || d.phyPmtBit || d.phyBasicBit;

		// helper counts for timing checks
		if (d.st == RSS_RDYWAIT || d.st == RSS_WAKE)
			d.waitCnt = (q.st == d.st) ? q.waitCnt + 1'b1 : rss_count_t'(1);
		else
			d.waitCnt = '0;
		d.softCnt = q.softBit ? q.softCnt + 1'b1 : '0;
	end

	// power-up behaves as a hardware reset held active
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			q <= '0;
			q.st <= RSS_HARD;
			q.pllRst <= 1'b1;
			q.hostBusRst <= 1'b1;
			q.keptRegsRst <= 1'b1;
			q.miiRst <= 1'b1;
			q.macRst <= 1'b1;
			q.phyRst <= 1'b1;
		end
		else
			q <= d;
	end

	// R19 request bits read back from their own flops
	assign pllRst = q.pllRst;
	assign hostBusRst = q.hostBusRst;
	assign keptRegsRst = q.keptRegsRst;
	assign miiRst = q.miiRst;
	assign macRst = q.macRst;
	assign phyRst = q.phyRst;
	assign readyBit = q.ready;
	assign eepromBusyFlag = q.eeBusy;
	assign eepromReload = q.reload;
	assign softResetRequest = q.softBit;
	assign phyPmtResetBit = q.phyPmtBit;
	assign phyBasicResetBit = q.phyBasicBit;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence pinReleased;
		$fell(pllRst);
	endsequence

	sequence softEnded;
		$fell(softResetRequest) && !pllRst;
	endsequence

	pin_all_a: assert property (hard |=> pllRst && hostBusRst && keptRegsRst && miiRst && macRst && phyRst) // R02
		else $error("pin reset missed a domain");
	ready_low_a: assert property (hard |=> !readyBit) // R09
		else $error("ready set while pin low");
	release_reload_a: assert property (pinReleased |-> eepromReload && eepromBusyFlag) // R16
		else $error("no eeprom reload at pin release");
	soft_scope_a: assert property (softResetRequest && !pllRst |-> hostBusRst && miiRst && macRst && !keptRegsRst) // R03
		else $error("soft reset domain wrong");
	soft_len_a: assert property (softEnded |-> q.softCnt == SOFT_LEN) // R07
		else $error("soft reset length wrong");
	soft_reload_a: assert property (softEnded |-> eepromReload ##1 eepromBusyFlag) // R03
		else $error("no reload after soft reset");
	soft_source_a: assert property ($rose(softResetRequest) |-> $past(softResetWrite) && $past(readyBit)) // R15
		else $error("soft bit rose without request");
	phy_only_a: assert property (phyPmtResetBit && !softResetRequest && !pllRst |-> phyRst && !macRst && !hostBusRst) // R05
		else $error("phy reset leaked");
	phy_basic_a: assert property ($fell(phyBasicResetBit) && !pllRst && !phyPmtResetBit |-> !phyRst) // R06
		else $error("basic phy bit cleared early");
	phy_source_a: assert property ($rose(phyRst) && !pllRst |-> $past(phyRstWrite) || $past(phyBasicRstWrite)) // R01
		else $error("phy reset from unknown source");
	ready_delay_a: assert property ($rose(readyBit) && $past(q.st) == RSS_RDYWAIT |-> $past(q.waitCnt) == READY_LEN) // R10
		else $error("ready delay wrong");
	wake_bound_a: assert property (q.st == RSS_WAKE |-> q.waitCnt <= WAKE_LEN) // R14
		else $error("wake exceeded bound");
	kept_pin_a: assert property (keptRegsRst |-> pllRst) // R04
		else $error("preserved registers reset by soft reset");

endmodule : rss_reset_seq

// >>> design/rss_strap_latch.sv
/*
 Configuration strap latch: captures the strap inputs on a capture
 pulse and holds them until the next one.
 Assumes straps are stable around the release of the hardware reset.
*/
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_strap_latch #(
	parameter int W = `RSS_STRAP_W
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic capture,
	input wire logic [W-1:0] strapIn,
	output logic [W-1:0] strapQ
);
	import rss_pkg::*;

	typedef struct packed {
		logic [W-1:0] val;
	} rss_strap_t;

	rss_strap_t q;
	rss_strap_t d;

	// straps are taken by a clocked capture, never by the reset itself
	always_comb
	begin
		d = q;
		if (capture)
			d.val = strapIn;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			q <= W'(`RSS_STRAP_RST);
		else
			q <= d;
	end

	assign strapQ = q.val;

	strap_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		!capture |=> $stable(strapQ))
		else $error("straps changed without capture");

endmodule : rss_strap_latch

// >>> tb/rss_host_model.sv
/*
 Host processor model: turns the bench's requests into write pulses and
 keeps the host's side of the reset handshake.
 Assumes the want inputs are one-cycle pulses driven on the rising edge.
*/
`timescale 1ns/1ps

module rss_host_model #(
	parameter int ERR_CYC = 250
) (
	input wire logic clock,
	input wire logic readyBit,
	input wire logic rude,
	input wire logic wantSoft,
	input wire logic wantPmt,
	input wire logic wantBasic,
	input wire logic wantSleep,
	input wire logic wantWake,
	output logic softResetWrite,
	output logic phyRstWrite,
	output logic phyBasicRstWrite,
	output logic sleepEnter,
	output logic wakeWrite,
	output logic hostErr
);
	int lowCnt = 0;

	// writes wait for ready
	// rude lets the bench break this on purpose, soft reset only
	assign softResetWrite = wantSoft & (readyBit | rude);
	// no traffic is modelled; after a phy reset the host waits for link
	assign phyRstWrite = wantPmt & readyBit;
	assign phyBasicRstWrite = wantBasic & readyBit;
	assign sleepEnter = wantSleep & readyBit;
	// wake write is the only write allowed while not ready
	assign wakeWrite = wantWake;

	always @(posedge clock)
		lowCnt <= readyBit ? 0 : lowCnt + 1;
	assign hostErr = lowCnt > ERR_CYC; // scaled from the host's long timeout
endmodule : rss_host_model

// >>> tb/tb_rss_reset_seq.sv
/*
 Self-checking bench of the reset source sequencer with short counts.
 Assumes the design files and rss_defs.svh are compiled alongside.
*/
`timescale 1ns/1ps
`include "rss_defs.svh"

module tb_rss_reset_seq;
	localparam int PHYC = 20;
	localparam int RDYC = 50;
	localparam int WAKEC = 30;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic hardResetPinLow = 1'b1;
	logic rude = 1'b0;
	logic wSoft = 1'b0;
	logic wPmt = 1'b0;
	logic wBasic = 1'b0;
	logic wSleep = 1'b0;
	logic wWake = 1'b0;
	logic [3:0] strap = 4'h9;
	logic softW, pmtW, basicW, sleepE, wakeW, hostErr;
	logic pllRst, hostBusRst, keptRegsRst, miiRst, macRst, phyRst;
	logic readyBit, eepromBusyFlag, eepromReload;
	logic softResetRequest, phyPmtResetBit, phyBasicResetBit;
	logic [3:0] strapLatched;
	logic [5:0] rsts;
	int err_count = 0;
	int checks_done = 0;

	// all domain resets as one vector, pll first
	assign rsts = {pllRst, hostBusRst, keptRegsRst, miiRst, macRst, phyRst};

	// 200 MHz clock
	initial
	begin
		forever #2.5 clock = ~clock;
	end

	rss_host_model host (.clock(clock), .readyBit(readyBit), .rude(rude), .wantSoft(wSoft),
		.wantPmt(wPmt), .wantBasic(wBasic), .wantSleep(wSleep), .wantWake(wWake),
		.softResetWrite(softW), .phyRstWrite(pmtW), .phyBasicRstWrite(basicW),
		.sleepEnter(sleepE), .wakeWrite(wakeW), .hostErr(hostErr));

	rss_reset_seq #(.PHY_RST_CYC(PHYC), .READY_CYC(RDYC), .WAKE_CYC(WAKEC)) dut (.clock(clock),
		.nrst(nrst), .hardResetPinLow(hardResetPinLow), .softResetWrite(softW),
		.phyRstWrite(pmtW), .phyBasicRstWrite(basicW), .sleepEnter(sleepE),
		.wakeWrite(wakeW), .strapIn(strap), .pllRst(pllRst), .hostBusRst(hostBusRst),
		.keptRegsRst(keptRegsRst), .miiRst(miiRst), .macRst(macRst), .phyRst(phyRst),
		.readyBit(readyBit), .eepromBusyFlag(eepromBusyFlag), .eepromReload(eepromReload),
		.softResetRequest(softResetRequest), .phyPmtResetBit(phyPmtResetBit),
		.phyBasicResetBit(phyBasicResetBit), .strapLatched(strapLatched));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_cnt(input int got, input int exp);
		checks_done++;
		if (got != exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check_cnt

	// sample 1 ns after the edge so the design's updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic drive(input int s, input logic v);
		case (s)
			0: wSoft <= v;
			1: wPmt <= v;
			2: wBasic <= v;
			3: wSleep <= v;
			default: wWake <= v;
		endcase
	endtask : drive

	// one-cycle request; returns just after the edge that takes it
	task automatic pulse(input int s);
		@(posedge clock);
		drive(s, 1'b1);
		@(posedge clock);
		drive(s, 1'b0);
		#1;
	endtask : pulse

	function automatic logic pick(input int s);
		case (s)
			0: return softResetRequest;
			1: return phyPmtResetBit;
			2: return phyBasicResetBit;
			3: return readyBit;
			default: return eepromBusyFlag;
		endcase
	endfunction : pick

	// bounded count of samples a flag keeps the value v
	task automatic run_len(input int s, input logic v, output int n);
		n = 0;
		while (pick(s) === v && n < 5000)
		begin
			n++;
			tick(1);
		end
	endtask : run_len

	// called just after the edge that takes the release of reset
	task automatic boot_check(input logic [3:0] sv);
		int n;
		check_val(rsts, 8'h00);
		check_val(readyBit, 8'h00);
		check_val(eepromReload, 8'h01);
		check_val(eepromBusyFlag, 8'h01);
		tick(1);
		check_val(eepromReload, 8'h00);
		check_val(strapLatched, sv);
		run_len(3, 1'b0, n);
		check_cnt(n + 1, RDYC);
		run_len(4, 1'b1, n);
		check_cnt(n + RDYC, `RSS_EE_PROBE_CYC);
	endtask : boot_check

	task automatic t_soft;
		int n;
		pulse(0);
		check_val(softResetRequest, 8'h01);
		check_val(rsts, 8'h16);
		run_len(0, 1'b1, n);
		check_cnt(n, `RSS_SOFT_RST_CYC);
		check_val(rsts, 8'h00);
		check_val(eepromReload, 8'h01);
		check_val(strapLatched, 8'h09);
		run_len(4, 1'b1, n);
		check_cnt(n, `RSS_EE_PROBE_CYC);
	endtask : t_soft

	task automatic t_phy;
		int n;
		pulse(2);
		check_val(rsts, 8'h01);
		run_len(2, 1'b1, n);
		check_cnt(n, PHYC);
		pulse(1);
		tick(3);
		pulse(2);
		check_val(phyBasicResetBit, 8'h01);
		run_len(1, 1'b1, n);
		check_cnt(n, PHYC - 5);
		check_val({phyBasicResetBit, rsts}, 8'h00);
	endtask : t_phy

	task automatic t_wake;
		int n;
		pulse(3);
		check_val({readyBit, rsts}, 8'h00);
		@(posedge clock);
		rude <= 1'b1;
		pulse(0);
		check_val({softResetRequest, rsts}, 8'h00);
		@(posedge clock);
		rude <= 1'b0;
		pulse(4);
		run_len(3, 1'b0, n);
		check_cnt(n, WAKEC);
	endtask : t_wake

	task automatic t_pin;
		@(posedge clock);
		hardResetPinLow <= 1'b0;
		tick(3);
		check_val({readyBit, rsts}, 8'h3f);
		// pin released high again, new straps
		@(posedge clock);
		strap <= 4'h6;
		hardResetPinLow <= 1'b1;
		tick(1);
		boot_check(4'h6);
	endtask : t_pin

	// main sequence; the power-up release acts as a pin release
	initial
	begin
		repeat (2) @(posedge clock);
		#1;
		check_val({readyBit, rsts}, 8'h3f);
		@(posedge clock);
		nrst <= 1'b1;
		tick(1);
		boot_check(4'h9);
		t_soft();
		t_phy();
		t_wake();
		t_pin();
		check_val(hostErr, 8'h00);
		wrap_up();
	end

	// hang guard, a few times the expected run of about 32 us
	initial
	begin
		#200000;
		err_count++;
		wrap_up();
	end
endmodule : tb_rss_reset_seq
